// [design/frm_pkg.sv]
// Package for the file record and masked register write server.
// Assumes a transport that hands over one whole request PDU byte by byte and takes the answer the same way.
package frm_pkg;
  localparam logic [7:0]  FC_READ_FILE  = 8'h14;
  localparam logic [7:0]  FC_WRITE_FILE = 8'h15;
  localparam logic [7:0]  FC_MASK_WRITE = 8'h16;
  localparam logic [7:0]  FC_ERR_FLAG   = 8'h80;
  localparam logic [7:0]  REF_TYPE      = 8'h06;
  localparam logic [7:0]  BC_MIN        = 8'h07;
  localparam logic [7:0]  BC_MAX        = 8'hF5;
  localparam logic [7:0]  PDU_MAX       = 8'hFD;
  localparam logic [7:0]  SUB_HDR_LEN   = 8'h07;
  localparam logic [7:0]  MASK_PDU_LEN  = 8'h07;
  localparam logic [15:0] REC_LAST      = 16'h270F;
  localparam logic [7:0]  EXC_FUNC      = 8'h01;
  localparam logic [7:0]  EXC_ADDR      = 8'h02;
  localparam logic [7:0]  EXC_VALUE     = 8'h03;
  localparam logic [7:0]  EXC_FAIL      = 8'h04;
  localparam logic [7:0]  EXC_PARITY    = 8'h08;

  typedef enum logic [3:0] {
    S_RECV   = 4'h0,
    S_DECODE = 4'h1,
    S_SUBHDR = 4'h2,
    S_XREQ   = 4'h3,
    S_XWAIT  = 4'h4,
    S_MRD    = 4'h5,
    S_MWR    = 4'h6,
    S_FINISH = 4'h7,
    S_SEND   = 4'h8
  } frm_state_type;

  typedef struct packed {
    logic        hold;
    logic        we;
    logic [15:0] file;
    logic [15:0] addr;
    logic [15:0] wdata;
  } frm_st_cmd_type;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } frm_st_rsp_type;

  function automatic logic [15:0] be16(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction
endpackage

// [design/frm_mask_merge.sv]
// Masked merge of one holding register value.
// Assumes the caller registers the result before it leaves the block.
`timescale 1ns/100ps
`default_nettype none
module frm_mask_merge (
  input  wire logic [15:0] cur,
  input  wire logic [15:0] and_mask,
  input  wire logic [15:0] or_mask,
  output logic      [15:0] result
);
  // Bits kept by the AND mask come from the register, the rest from the OR mask.
  assign result = (cur & and_mask) | (or_mask & ~and_mask);
endmodule // frm_mask_merge
`default_nettype wire

// [design/frm_server.sv]
// Request interpreter for file record read, file record write and masked register write.
// Assumes whole request frames on the rx stream and a storage port that acknowledges each access.
`timescale 1ns/100ps
`default_nettype none
module frm_server (
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  input  wire logic                    rx_valid,
  input  wire logic [7:0]              rx_data,
  input  wire logic                    rx_last,
  output logic                         rx_ready,
  output logic                         tx_valid,
  output logic [7:0]                   tx_data,
  output logic                         tx_last,
  input  wire logic                    tx_ready,
  output logic                         st_req,
  output frm_pkg::frm_st_cmd_type      st_cmd,
  input  wire frm_pkg::frm_st_rsp_type st_rsp
);
  // Whole frames are held so that an exception can still replace a half built answer.
  logic [7:0]              rx_mem [256];
  logic [7:0]              tx_mem [256];
  frm_pkg::frm_state_type  state_q;
  logic [7:0]              rlen_q, fc_q, bc_q, ptr_q, op_q, tlen_q, tptr_q;
  logic                    rx_ovf_q, exc_q, first_q;
  logic [15:0]             nwords_q, rec_q, file_q, mask_and_q, mask_or_q, merged;
  logic                    rx_take, rx_done, tx_move;
  logic [15:0]             s_file, s_rec, s_len;
  logic [17:0]             s_end;

  assign rx_take = rx_valid && rx_ready;
  assign rx_done = rx_take && rx_last;
  assign tx_move = !tx_valid || tx_ready;
  assign s_file  = frm_pkg::be16(rx_mem[ptr_q + 8'h01], rx_mem[ptr_q + 8'h02]);
  assign s_rec   = frm_pkg::be16(rx_mem[ptr_q + 8'h03], rx_mem[ptr_q + 8'h04]);
  assign s_len   = frm_pkg::be16(rx_mem[ptr_q + 8'h05], rx_mem[ptr_q + 8'h06]);
  assign s_end   = (fc_q == frm_pkg::FC_READ_FILE) ? 18'(op_q) + 18'h0_0002 + {1'b0, s_len, 1'b0}
                                                   : 18'(ptr_q) + 18'h0_0007 + {1'b0, s_len, 1'b0};

  frm_mask_merge u_merge (
    .cur      (st_rsp.rdata),
    .and_mask (mask_and_q),
    .or_mask  (mask_or_q),
    .result   (merged)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rlen_q   <= 8'h00;
      rx_ovf_q <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= (state_q == frm_pkg::S_RECV) && !rx_done;
      if (rx_take) begin
        rx_mem[rlen_q] <= rx_data;
        if (rlen_q == frm_pkg::PDU_MAX) begin
          rx_ovf_q <= 1'b1;
        end else begin
          rlen_q <= rlen_q + 8'h01;
        end
      end
      if (state_q == frm_pkg::S_SEND) begin
        rlen_q   <= 8'h00;
        rx_ovf_q <= 1'b0;
      end
    end
  end

  task automatic fail(input logic [7:0] code);
    tx_mem[0] <= fc_q | frm_pkg::FC_ERR_FLAG;
    tx_mem[1] <= code;
    tlen_q    <= 8'h02;
    exc_q     <= 1'b1;
    st_req    <= 1'b0;
    state_q   <= frm_pkg::S_FINISH;
  endtask

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q    <= frm_pkg::S_RECV;
      fc_q       <= 8'h00;
      bc_q       <= 8'h00;
      ptr_q      <= 8'h00;
      op_q       <= 8'h00;
      tlen_q     <= 8'h00;
      exc_q      <= 1'b0;
      nwords_q   <= 16'h0000;
      rec_q      <= 16'h0000;
      file_q     <= 16'h0000;
      mask_and_q <= 16'h0000;
      mask_or_q  <= 16'h0000;
      st_req     <= 1'b0;
      st_cmd     <= '0;
    end else begin
      unique case (state_q)
        frm_pkg::S_RECV: begin
          exc_q <= 1'b0;
          if (rx_done) begin
            state_q <= frm_pkg::S_DECODE;
          end
        end
        frm_pkg::S_DECODE: begin
          fc_q      <= rx_mem[0];
          bc_q      <= rx_mem[1];
          ptr_q     <= 8'h02;
          op_q      <= 8'h02;
          tx_mem[0] <= rx_mem[0];
          state_q   <= frm_pkg::S_SUBHDR;
          if (rx_mem[0] == frm_pkg::FC_MASK_WRITE) begin
            mask_and_q <= frm_pkg::be16(rx_mem[3], rx_mem[4]);
            mask_or_q  <= frm_pkg::be16(rx_mem[5], rx_mem[6]);
            st_cmd     <= '{hold: 1'b1, we: 1'b0, file: 16'h0000,
                            addr: frm_pkg::be16(rx_mem[1], rx_mem[2]), wdata: 16'h0000};
            state_q    <= frm_pkg::S_MRD;
          end
          // The task uses fc_q, so the code is taken from the buffer here.
          if (rx_mem[0] != frm_pkg::FC_READ_FILE && rx_mem[0] != frm_pkg::FC_WRITE_FILE
              && rx_mem[0] != frm_pkg::FC_MASK_WRITE) begin
            tx_mem[0] <= rx_mem[0] | frm_pkg::FC_ERR_FLAG;
            tx_mem[1] <= frm_pkg::EXC_FUNC;
            tlen_q    <= 8'h02;
            exc_q     <= 1'b1;
            state_q   <= frm_pkg::S_FINISH;
          end else if (rx_ovf_q || (rx_mem[0] == frm_pkg::FC_MASK_WRITE ? rlen_q != frm_pkg::MASK_PDU_LEN
                       : (rx_mem[1] < frm_pkg::BC_MIN || rx_mem[1] > frm_pkg::BC_MAX
                          || rlen_q != rx_mem[1] + 8'h02))) begin
            tx_mem[0] <= rx_mem[0] | frm_pkg::FC_ERR_FLAG;
            tx_mem[1] <= frm_pkg::EXC_VALUE;
            tlen_q    <= 8'h02;
            exc_q     <= 1'b1;
            state_q   <= frm_pkg::S_FINISH;
          end
        end
        frm_pkg::S_SUBHDR: begin
          if (ptr_q == bc_q + 8'h02) begin
            tx_mem[1] <= (fc_q == frm_pkg::FC_READ_FILE) ? op_q - 8'h02 : bc_q;
            tlen_q    <= (fc_q == frm_pkg::FC_READ_FILE) ? op_q : bc_q + 8'h02;
            state_q   <= frm_pkg::S_FINISH;
          end else if (9'(ptr_q) + 9'(frm_pkg::SUB_HDR_LEN) > 9'(bc_q) + 9'h002 || s_len == 16'h0000) begin
            fail(frm_pkg::EXC_VALUE);
          end else if (rx_mem[ptr_q] != frm_pkg::REF_TYPE || s_rec > frm_pkg::REC_LAST
                       || 17'(s_rec) + 17'(s_len) - 17'h0_0001 > 17'(frm_pkg::REC_LAST)) begin
            fail(frm_pkg::EXC_ADDR);
          end else if ((fc_q == frm_pkg::FC_READ_FILE && s_end > 18'(frm_pkg::PDU_MAX))
                       || (fc_q == frm_pkg::FC_WRITE_FILE && s_end > 18'(bc_q) + 18'h0_0002)) begin
            fail(frm_pkg::EXC_VALUE);
          end else begin
            file_q   <= s_file;
            rec_q    <= s_rec;
            nwords_q <= s_len;
            if (fc_q == frm_pkg::FC_READ_FILE) begin
              tx_mem[op_q]         <= 8'(s_len << 1) + 8'h01;
              tx_mem[op_q + 8'h01] <= frm_pkg::REF_TYPE;
              op_q                 <= op_q + 8'h02;
            end else begin
              for (int i = 0; i < 7; i++) begin
                tx_mem[ptr_q + 8'(i)] <= rx_mem[ptr_q + 8'(i)];
              end
            end
            ptr_q   <= ptr_q + frm_pkg::SUB_HDR_LEN;
            state_q <= frm_pkg::S_XREQ;
          end
        end
        frm_pkg::S_XREQ: begin
          st_req  <= 1'b1;
          st_cmd  <= '{hold: 1'b0, we: fc_q == frm_pkg::FC_WRITE_FILE, file: file_q, addr: rec_q,
                       wdata: frm_pkg::be16(rx_mem[ptr_q], rx_mem[ptr_q + 8'h01])};
          state_q <= frm_pkg::S_XWAIT;
        end
        frm_pkg::S_XWAIT: begin
          if (st_rsp.ack) begin
            st_req <= 1'b0;
            if (st_rsp.err) begin
              fail(frm_pkg::EXC_PARITY);
            end else begin
              if (fc_q == frm_pkg::FC_READ_FILE) begin
                tx_mem[op_q]         <= st_rsp.rdata[15:8];
                tx_mem[op_q + 8'h01] <= st_rsp.rdata[7:0];
                op_q                 <= op_q + 8'h02;
              end else begin
                tx_mem[ptr_q]         <= rx_mem[ptr_q];
                tx_mem[ptr_q + 8'h01] <= rx_mem[ptr_q + 8'h01];
                ptr_q                 <= ptr_q + 8'h02;
              end
              rec_q    <= rec_q + 16'h0001;
              nwords_q <= nwords_q - 16'h0001;
              state_q  <= (nwords_q == 16'h0001) ? frm_pkg::S_SUBHDR : frm_pkg::S_XREQ;
            end
          end
        end
        frm_pkg::S_MRD: begin
          st_req <= 1'b1;
          if (st_req && st_rsp.ack) begin
            st_req <= 1'b0;
            if (st_rsp.err) begin
              fail(frm_pkg::EXC_FAIL);
            end else begin
              st_cmd.we    <= 1'b1;
              st_cmd.wdata <= merged;
              state_q      <= frm_pkg::S_MWR;
            end
          end
        end
        frm_pkg::S_MWR: begin
          st_req <= 1'b1;
          if (st_req && st_rsp.ack) begin
            st_req <= 1'b0;
            if (st_rsp.err) begin
              fail(frm_pkg::EXC_FAIL);
            end else begin
              for (int i = 0; i < 7; i++) begin
                tx_mem[i] <= rx_mem[i];
              end
              tlen_q  <= frm_pkg::MASK_PDU_LEN;
              state_q <= frm_pkg::S_FINISH;
            end
          end
        end
        frm_pkg::S_FINISH: begin
          state_q <= frm_pkg::S_SEND;
        end
        frm_pkg::S_SEND: begin
          if (tx_valid && tx_ready && tx_last) begin
            state_q <= frm_pkg::S_RECV;
          end
        end
        default: begin
          state_q <= frm_pkg::S_RECV;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tptr_q   <= 8'h00;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      first_q  <= 1'b0;
    end else if (state_q != frm_pkg::S_SEND) begin
      tptr_q   <= 8'h00;
      tx_valid <= 1'b0;
      first_q  <= 1'b0;
    end else if (tx_move) begin
      tx_valid <= tptr_q < tlen_q;
      tx_data  <= tx_mem[tptr_q];
      tx_last  <= tptr_q == tlen_q - 8'h01;
      first_q  <= tptr_q == 8'h00;
      tptr_q   <= (tptr_q < tlen_q) ? tptr_q + 8'h01 : tptr_q;
    end
  end

  logic mask_done_q;
  always_ff @(posedge clk_sys) begin
    if (srst || state_q == frm_pkg::S_RECV) begin
      mask_done_q <= 1'b0;
    end else if (state_q == frm_pkg::S_MWR && st_req && st_rsp.ack) begin
      mask_done_q <= 1'b1;
    end
  end

  property p_first_byte;
    @(posedge clk_sys) disable iff (srst)
      tx_valid && first_q |-> tx_data == fc_q || tx_data == (fc_q | frm_pkg::FC_ERR_FLAG) || exc_q;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("first answer byte is not the function code");
  property p_exc_len;
    @(posedge clk_sys) disable iff (srst)
      state_q == frm_pkg::S_FINISH && exc_q |-> tlen_q == 8'h02 && tx_mem[0][7];
  endproperty
  a_exc_len: assert property (p_exc_len) else $error("exception answer malformed");
  property p_rec_range;
    @(posedge clk_sys) disable iff (srst)
      st_req && !st_cmd.hold |-> st_cmd.addr <= frm_pkg::REC_LAST;
  endproperty
  a_rec_range: assert property (p_rec_range) else $error("record address out of range");
  property p_merge;
    @(posedge clk_sys) disable iff (srst)
      state_q == frm_pkg::S_MRD && st_req && st_rsp.ack && !st_rsp.err |=>
        st_cmd.wdata == (($past(st_rsp.rdata) & mask_and_q) | (mask_or_q & ~mask_and_q));
  endproperty
  a_merge: assert property (p_merge) else $error("masked value wrong");
  property p_mask_after;
    @(posedge clk_sys) disable iff (srst)
      $rose(tx_valid) && fc_q == frm_pkg::FC_MASK_WRITE && !exc_q |-> mask_done_q && tlen_q == 8'h07;
  endproperty
  a_mask_after: assert property (p_mask_after) else $error("mask echo before update");
  property p_read_total;
    @(posedge clk_sys) disable iff (srst)
      state_q == frm_pkg::S_FINISH && !exc_q && fc_q == frm_pkg::FC_READ_FILE |->
        tx_mem[1] == tlen_q - 8'h02 && tlen_q <= frm_pkg::PDU_MAX;
  endproperty
  a_read_total: assert property (p_read_total) else $error("read byte count wrong");
  property p_write_echo;
    @(posedge clk_sys) disable iff (srst)
      state_q == frm_pkg::S_FINISH && !exc_q && fc_q == frm_pkg::FC_WRITE_FILE |-> tlen_q == bc_q + 8'h02;
  endproperty
  a_write_echo: assert property (p_write_echo) else $error("write echo length wrong");
  property p_bad_count;
    @(posedge clk_sys) disable iff (srst)
      state_q == frm_pkg::S_DECODE && rx_mem[0] == frm_pkg::FC_READ_FILE && rx_mem[1] > frm_pkg::BC_MAX
        |=> exc_q && state_q == frm_pkg::S_FINISH ##1 state_q == frm_pkg::S_SEND;
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("bad byte count accepted");

  c_read:  cover property (@(posedge clk_sys) disable iff (srst)
             state_q == frm_pkg::S_FINISH && !exc_q && fc_q == frm_pkg::FC_READ_FILE);
  c_write: cover property (@(posedge clk_sys) disable iff (srst)
             state_q == frm_pkg::S_FINISH && !exc_q && fc_q == frm_pkg::FC_WRITE_FILE);
  c_mask:  cover property (@(posedge clk_sys) disable iff (srst) $rose(mask_done_q));
  c_exc:   cover property (@(posedge clk_sys) disable iff (srst) state_q == frm_pkg::S_FINISH && exc_q);
endmodule // frm_server
`default_nettype wire

// [verification/frm_store_model.sv]
// Behavioural record and holding register storage facing the server's storage port.
// Assumes the bench presets words in mem and sets lat and err_on by hierarchical reference.
`timescale 1ns/100ps
`default_nettype none
module frm_store_model (
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  input  wire logic                    st_req,
  input  wire frm_pkg::frm_st_cmd_type st_cmd,
  output var  frm_pkg::frm_st_rsp_type st_rsp
);
  logic [15:0] mem [logic [32:0]];
  logic [32:0] key;
  logic        err_on;
  int          lat;
  int          wait_q;

  initial begin
    lat = 0;
    err_on = 1'b0;
  end

  // Record numbers index directly and holding addresses are zero based.
  assign key = {st_cmd.hold, st_cmd.file, st_cmd.addr};

  // Data outside an answer is inverted each cycle, so a stale word matches the fresh one on every second cycle.
  always @(posedge clk_sys) begin
    if (srst) begin
      st_rsp <= '0;
      wait_q <= 0;
    end else if (st_req && !st_rsp.ack && wait_q >= lat) begin
      st_rsp.ack <= 1'b1;
      st_rsp.err <= err_on;
      st_rsp.rdata <= mem.exists(key) ? mem[key] : 16'h5A5A;
      if (st_cmd.we && !err_on) mem[key] = st_cmd.wdata;
      wait_q <= 0;
    end else begin
      st_rsp.ack <= 1'b0;
      st_rsp.err <= 1'b0;
      st_rsp.rdata <= ~st_rsp.rdata;
      wait_q <= st_req ? wait_q + 1 : 0;
    end
  end
endmodule // frm_store_model
`default_nettype wire

// [verification/frm_server_bench.sv]
// Self-checking bench for the file record and masked register server.
// Assumes frm_store_model as the storage side and whole request frames from the bench.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module frm_server_bench;
  logic                    clk_sys;
  logic                    srst;
  logic                    rx_valid;
  logic [7:0]              rx_data;
  logic                    rx_last;
  logic                    rx_ready;
  logic                    tx_valid;
  logic [7:0]              tx_data;
  logic                    tx_last;
  logic                    tx_ready;
  logic                    st_req;
  frm_pkg::frm_st_cmd_type st_cmd;
  frm_pkg::frm_st_rsp_type st_rsp;
  logic                    stall;
  int                      miscompares;
  int                      checked;

  frm_server u_dut (.clk_sys(clk_sys), .srst(srst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .st_req(st_req), .st_cmd(st_cmd), .st_rsp(st_rsp));
  frm_store_model u_st (.clk_sys(clk_sys), .srst(srst), .st_req(st_req), .st_cmd(st_cmd), .st_rsp(st_rsp));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait on a ready signal that only changes at clock edges.
  task automatic hang_check(input int w);
    if (w > 3000) begin
      miscompares++;
      $display("MISMATCH handshake expected 1 seen 0");
      end_sim;
    end
  endtask

  task automatic xfer(input logic [7:0] q[$], input logic [7:0] e[$]);
    logic [7:0] r[$];
    logic       last;
    int         i;
    int         w;
    for (i = 0; i < q.size(); i++) begin
      rx_valid = 1'b1;
      rx_data = q[i];
      rx_last = (i == q.size() - 1);
      w = 0;
      while (rx_ready !== 1'b1) begin
        @(posedge clk_sys);
        #1 w++;
        hang_check(w);
      end
      @(posedge clk_sys);
      #1;
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
    last = 1'b0;
    while (!last) begin
      w = 0;
      while (!(tx_valid === 1'b1 && tx_ready)) begin
        @(posedge clk_sys);
        #1 w++;
        if (stall) tx_ready = ~tx_ready;
        hang_check(w);
      end
      r.push_back(tx_data);
      last = (tx_last === 1'b1);
      @(posedge clk_sys);
      // Ready is left high after the last byte so the next frame starts unstalled.
      #1 tx_ready = !stall || last;
    end
    `CHK("answer length", e.size(), r.size())
    for (i = 0; i < e.size() && i < r.size(); i++) `CHK("answer byte", e[i], r[i])
  endtask

  task automatic t_mask;
    u_st.mem[{1'b1, 16'h0000, 16'h0004}] = 16'h0012;
    xfer('{8'h16, 8'h00, 8'h04, 8'h00, 8'hF2, 8'h00, 8'h25}, '{8'h16, 8'h00, 8'h04, 8'h00, 8'hF2, 8'h00, 8'h25});
    `CHK("holding 4", 16'h0017, u_st.mem[{1'b1, 16'h0000, 16'h0004}])
    u_st.mem[{1'b1, 16'h0000, 16'h000F}] = 16'hFFFF;
    xfer('{8'h16, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h12, 8'h34}, '{8'h16, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h12, 8'h34});
    `CHK("holding 15", 16'h1234, u_st.mem[{1'b1, 16'h0000, 16'h000F}])
    $display("test mask done");
  endtask

  // Slow storage and a stalling sink together stress every hold rule of the answer path.
  task automatic t_read;
    u_st.mem[{1'b0, 16'h0004, 16'h0001}] = 16'h0DFE;
    u_st.mem[{1'b0, 16'h0004, 16'h0002}] = 16'h0020;
    u_st.mem[{1'b0, 16'h0003, 16'h0009}] = 16'h33CD;
    u_st.mem[{1'b0, 16'h0003, 16'h000A}] = 16'h0040;
    u_st.mem[{1'b0, 16'h0001, 16'h270F}] = 16'hBEEF;
    u_st.lat = 3;
    stall = 1'b1;
    xfer('{8'h14, 8'h0E, 8'h06, 8'h00, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02, 8'h06, 8'h00, 8'h03, 8'h00, 8'h09,
      8'h00, 8'h02}, '{8'h14, 8'h0C, 8'h05, 8'h06, 8'h0D, 8'hFE, 8'h00, 8'h20, 8'h05, 8'h06, 8'h33, 8'hCD, 8'h00,
      8'h40});
    stall = 1'b0;
    u_st.lat = 0;
    xfer('{8'h14, 8'h07, 8'h06, 8'h00, 8'h01, 8'h27, 8'h0F, 8'h00, 8'h01},
      '{8'h14, 8'h04, 8'h03, 8'h06, 8'hBE, 8'hEF});
    $display("test read done");
  endtask

  task automatic t_write;
    xfer('{8'h15, 8'h0D, 8'h06, 8'h00, 8'h04, 8'h00, 8'h07, 8'h00, 8'h03, 8'h06, 8'hAF, 8'h04, 8'hBE, 8'h10, 8'h0D},
      '{8'h15, 8'h0D, 8'h06, 8'h00, 8'h04, 8'h00, 8'h07, 8'h00, 8'h03, 8'h06, 8'hAF, 8'h04, 8'hBE, 8'h10,
      8'h0D});
    `CHK("record 7", 16'h06AF, u_st.mem[{1'b0, 16'h0004, 16'h0007}])
    `CHK("record 9", 16'h100D, u_st.mem[{1'b0, 16'h0004, 16'h0009}])
    $display("test write done");
  endtask

  task automatic t_err;
    logic [7:0] big[$];
    xfer('{8'h2B}, '{8'hAB, 8'h01});
    xfer('{8'h14, 8'h07, 8'h05, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h94, 8'h02});
    xfer('{8'h14, 8'h07, 8'h06, 8'h00, 8'h01, 8'h27, 8'h10, 8'h00, 8'h01}, '{8'h94, 8'h02});
    xfer('{8'h14, 8'h07, 8'h06, 8'h00, 8'h01, 8'h27, 8'h0F, 8'h00, 8'h02}, '{8'h94, 8'h02});
    xfer('{8'h15, 8'h06, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00}, '{8'h95, 8'h03});
    xfer('{8'h16, 8'h00, 8'h04, 8'h00, 8'hF2, 8'h00}, '{8'h96, 8'h03});
    xfer('{8'h14, 8'hF6, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h94, 8'h03});
    xfer('{8'h14, 8'h07, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h94, 8'h03});
    xfer('{8'h14, 8'h08, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00}, '{8'h94, 8'h03});
    xfer('{8'h15, 8'h09, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02, 8'h12, 8'h34}, '{8'h95, 8'h03});
    // A frame one byte past the limit must be refused even with a legal header.
    big.push_back(8'h14);
    big.push_back(8'hF5);
    repeat (252) big.push_back(8'h00);
    xfer(big, '{8'h94, 8'h03});
    u_st.err_on = 1'b1;
    xfer('{8'h14, 8'h07, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h94, 8'h08});
    xfer('{8'h15, 8'h09, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h12, 8'h34}, '{8'h95, 8'h08});
    xfer('{8'h16, 8'h00, 8'h04, 8'h00, 8'hF2, 8'h00, 8'h25}, '{8'h96, 8'h04});
    u_st.err_on = 1'b0;
    $display("test errors done");
  endtask

  initial begin
    miscompares = 0;
    checked = 0;
    srst = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
    stall = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1 srst = 1'b0;
    t_mask;
    t_read;
    t_write;
    t_err;
    end_sim;
  end
endmodule // frm_server_bench
`default_nettype wire
